/* File: logic/skip_test_instruction_unit.sv */
// constants and execution logic for the one-word skip test instructions
//
// What this block does
// - compare skips next instruction when accumulator equals addressed nibble
// - ext0 test with enable 0 skips if request flag set, then clears it
// - ext0 test is a no-operation while ext0 enable bit 0 is set
// - pin test skips on low pin, or high pin when polarity bit 2 set
// - power-down test skips when the power-down flag is one
// - power-down test never modifies the power-down flag
// - timer1 test with enable 0 skips if request flag set, then clears it
// - timer1 test is a no-operation while timer1 enable bit 2 is set
// - timer2 test with enable 0 skips if request flag set, then clears it
// - timer2 test is a no-operation while timer2 enable bit 3 is set

// -------------------------------------------------------------------------
// package
// -------------------------------------------------------------------------
package skip_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NIB_W = 4;
	localparam int EV_W = 5;

	// register byte addresses
	localparam logic [7:0] ADDR_IRQ_EN = 8'h00;
	localparam logic [7:0] ADDR_PIN_CTRL = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_MASK = 8'h0C;
	localparam logic [7:0] ADDR_STATE = 8'h10;

	// field positions in irq_enable_reg_one and pin_irq_ctrl_reg_one
	localparam int EXT0_IE_BIT = 0;
	localparam int T1_IE_BIT = 2;
	localparam int T2_IE_BIT = 3;
	localparam int POL_BIT = 2;

	// event bits of the status and mask registers
	localparam int EV_SKIP = 0;
	localparam int EV_EXT0_CLR = 1;
	localparam int EV_T1_CLR = 2;
	localparam int EV_T2_CLR = 3;
	localparam int EV_DISABLED = 4;

	// reset values
	localparam logic [3:0] IRQ_EN_RST = 4'h0;
	localparam logic [3:0] PIN_CTRL_RST = 4'h0;
	localparam logic [4:0] STATUS_RST = 5'h00;
	localparam logic [4:0] MASK_RST = 5'h00;
	localparam logic PIN_RST_LEVEL = 1'b1;

	// decoded instruction kind handed in by the fetch stage
	typedef enum logic [2:0] {
		OP_OTHER = 3'b000,
		OP_SKIP_IF_ACC_EQUALS_MEM = 3'b001,
		OP_SKIP_ON_EXT0_REQUEST = 3'b010,
		OP_SKIP_ON_EXT0_PIN_LEVEL = 3'b011,
		OP_SKIP_ON_POWERDOWN_FLAG = 3'b100,
		OP_SKIP_ON_TIMER1_REQUEST = 3'b101,
		OP_SKIP_ON_TIMER2_REQUEST = 3'b110
	} op_t;

endpackage : skip_pkg

`timescale 1ns/1ns

// -------------------------------------------------------------------------
// top module
// -------------------------------------------------------------------------
module skip_test_instruction_unit (
	input wire logic core_clk,
	input wire logic sys_rst,
	// instruction stream
	input wire logic instr_valid,
	input wire skip_pkg::op_t instr_op,
	input wire logic [skip_pkg::NIB_W-1:0] acc_value,
	input wire logic [skip_pkg::NIB_W-1:0] mem_nibble,
	output logic instr_squash,
	output logic skip_next,
	// flag sources
	input wire logic ext0_request_flag,
	input wire logic timer1_request_flag,
	input wire logic timer2_request_flag,
	input wire logic powerdown_flag,
	input wire logic ext0_pin,
	output logic ext0_flag_clr,
	output logic timer1_flag_clr,
	output logic timer2_flag_clr,
	output logic irq,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [skip_pkg::ADDR_W-1:0] paddr,
	input wire logic [skip_pkg::DATA_W-1:0] pwdata,
	output logic [skip_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr
);
	import skip_pkg::*;

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] irq_enable_reg_one;
		logic [3:0] pin_irq_ctrl_reg_one;
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] mask;
		logic [DATA_W-1:0] rdata;
		logic rerr;
		logic skip_pending;
		logic ext0_clr;
		logic t1_clr;
		logic t2_clr;
		logic irq;
	} unit_state_t;

	localparam unit_state_t ST_RST = '{irq_enable_reg_one: IRQ_EN_RST,
		pin_irq_ctrl_reg_one: PIN_CTRL_RST, status: STATUS_RST,
		mask: MASK_RST, default: '0};

	unit_state_t st_r, st_nxt;
	logic pin_level, acc_eq, pin_match, ext0_eff, t1_eff, t2_eff;
	logic exec, skip, apb_wr, apb_setup;
	logic [EV_W-1:0] ev, w1c;

	// -----------------------------------------------------------------
	// pin synchroniser
	// -----------------------------------------------------------------
	ext_pin_sync #(.RST_LEVEL(PIN_RST_LEVEL)) u_pin_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.pin_async(ext0_pin),
		.pin_level(pin_level)
	);

	// -----------------------------------------------------------------
	// test conditions
	// -----------------------------------------------------------------
	// a flag whose clear pulse is still in flight reads as zero, so two
	// tests of the same flag back to back cannot both skip
	assign acc_eq = (acc_value == mem_nibble);
	assign pin_match = st_r.pin_irq_ctrl_reg_one[POL_BIT] ?
		pin_level : ~pin_level;
	assign ext0_eff = ext0_request_flag & ~st_r.ext0_clr;
	assign t1_eff = timer1_request_flag & ~st_r.t1_clr;
	assign t2_eff = timer2_request_flag & ~st_r.t2_clr;

	// an instruction arriving while a skip is pending is squashed to a nop
	assign instr_squash = instr_valid & st_r.skip_pending;
	assign exec = instr_valid & ~st_r.skip_pending;

	assign apb_setup = psel & ~penable;
	assign apb_wr = psel & penable & pwrite;

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		skip = 1'b0;
		ev = '0;
		w1c = '0;
		// clear strobes last one cycle only
		st_nxt.ext0_clr = 1'b0;
		st_nxt.t1_clr = 1'b0;
		st_nxt.t2_clr = 1'b0;

		// instruction execution, one per valid cycle with no skip pending
		if (exec)
		begin
			case (instr_op)
				OP_SKIP_IF_ACC_EQUALS_MEM:
					skip = acc_eq;
				OP_SKIP_ON_EXT0_REQUEST:
				begin
					if (st_r.irq_enable_reg_one[EXT0_IE_BIT])
					begin
						ev[EV_DISABLED] = 1'b1;
					end
					else
					begin
						skip = ext0_eff;
						st_nxt.ext0_clr = 1'b1;
						ev[EV_EXT0_CLR] = ext0_eff;
					end
				end
				OP_SKIP_ON_EXT0_PIN_LEVEL:
					skip = pin_match;
				OP_SKIP_ON_POWERDOWN_FLAG:
				begin
					// the flag is only read, no clear path exists
					skip = powerdown_flag;
				end
				OP_SKIP_ON_TIMER1_REQUEST:
				begin
					if (st_r.irq_enable_reg_one[T1_IE_BIT])
					begin
						ev[EV_DISABLED] = 1'b1;
					end
					else
					begin
						skip = t1_eff;
						st_nxt.t1_clr = 1'b1;
						ev[EV_T1_CLR] = t1_eff;
					end
				end
				OP_SKIP_ON_TIMER2_REQUEST:
				begin
					if (st_r.irq_enable_reg_one[T2_IE_BIT])
					begin
						ev[EV_DISABLED] = 1'b1;
					end
					else
					begin
						skip = t2_eff;
						st_nxt.t2_clr = 1'b1;
						ev[EV_T2_CLR] = t2_eff;
					end
				end
				default:
					skip = 1'b0;
			endcase
			st_nxt.skip_pending = skip;
			ev[EV_SKIP] = skip;
		end
		else if (instr_squash)
		begin
			// the squashed word used up its cycle as a nop
			st_nxt.skip_pending = 1'b0;
		end

		// register writes take effect at the access edge
		if (apb_wr)
		begin
			case (paddr)
				ADDR_IRQ_EN:
					st_nxt.irq_enable_reg_one = pwdata[3:0];
				ADDR_PIN_CTRL:
					st_nxt.pin_irq_ctrl_reg_one = pwdata[3:0];
				ADDR_STATUS:
					w1c = pwdata[EV_W-1:0];
				ADDR_MASK:
					st_nxt.mask = pwdata[EV_W-1:0];
				default:
					w1c = '0;
			endcase
		end

		// set wins over a write-one clear in the same cycle
		st_nxt.status = (st_r.status & ~w1c) | ev;
		st_nxt.irq = |(st_nxt.status & st_nxt.mask);

		// read data is captured in the setup cycle, so it shows the
		// state one cycle before the access edge
		if (apb_setup)
		begin
			st_nxt.rerr = 1'b0;
			case (paddr)
				ADDR_IRQ_EN:
					st_nxt.rdata = {28'h0000000, st_r.irq_enable_reg_one};
				ADDR_PIN_CTRL:
					st_nxt.rdata = {28'h0000000, st_r.pin_irq_ctrl_reg_one};
				ADDR_STATUS:
					st_nxt.rdata = {27'h0000000, st_r.status};
				ADDR_MASK:
					st_nxt.rdata = {27'h0000000, st_r.mask};
				ADDR_STATE:
					st_nxt.rdata = {26'h0000000, st_r.skip_pending,
						pin_level, powerdown_flag, timer2_request_flag,
						timer1_request_flag, ext0_request_flag};
				default:
				begin
					st_nxt.rdata = '0;
					st_nxt.rerr = 1'b1;
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// state register
	// -----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			st_r <= ST_RST;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// -----------------------------------------------------------------
	// outputs
	// -----------------------------------------------------------------
	assign skip_next = st_r.skip_pending;
	assign ext0_flag_clr = st_r.ext0_clr;
	assign timer1_flag_clr = st_r.t1_clr;
	assign timer2_flag_clr = st_r.t2_clr;
	assign irq = st_r.irq;
	// zero wait states: every access completes in its first access cycle
	assign pready = psel & penable;
	assign prdata = st_r.rdata;
	assign pslverr = psel & penable & st_r.rerr;

	// -----------------------------------------------------------------
	// assertions
	// -----------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// the extra condition rides inside the sequence, never beside it
	sequence run_op(op_t k, logic c);
		exec && instr_op == k && c;
	endsequence
	sequence skip_then_word;
		st_r.skip_pending ##0 instr_valid;
	endsequence
	acc_compare_a: assert property (
		run_op(OP_SKIP_IF_ACC_EQUALS_MEM, 1'b1)
		|=> skip_next == $past(acc_eq))
		else $error("compare skip does not follow equality");
	// a second enabled ext0 test right behind may pulse the clear again
	ext0_clear_a: assert property (
		run_op(OP_SKIP_ON_EXT0_REQUEST,
		!st_r.irq_enable_reg_one[EXT0_IE_BIT])
		|=> ext0_flag_clr && skip_next == $past(ext0_eff)
		##1 (!ext0_flag_clr || $past(exec
		&& instr_op == OP_SKIP_ON_EXT0_REQUEST)))
		else $error("ext0 test did not clear or skip correctly");
	ext0_disabled_a: assert property (
		run_op(OP_SKIP_ON_EXT0_REQUEST, st_r.irq_enable_reg_one[EXT0_IE_BIT])
		|=> !ext0_flag_clr && !skip_next)
		else $error("disabled ext0 test was not a nop");
	pin_polarity_a: assert property (
		run_op(OP_SKIP_ON_EXT0_PIN_LEVEL, 1'b1) |=> skip_next ==
		($past(pin_level) ^ !$past(st_r.pin_irq_ctrl_reg_one[POL_BIT])))
		else $error("pin test skip wrong for polarity");
	pdown_skip_a: assert property (
		run_op(OP_SKIP_ON_POWERDOWN_FLAG, 1'b1)
		|=> skip_next == $past(powerdown_flag))
		else $error("power-down test skip mismatch");
	pdown_untouched_a: assert property (
		run_op(OP_SKIP_ON_POWERDOWN_FLAG, 1'b1)
		|=> !ext0_flag_clr && !timer1_flag_clr && !timer2_flag_clr)
		else $error("power-down test raised a clear");
	timer1_test_a: assert property (
		run_op(OP_SKIP_ON_TIMER1_REQUEST, 1'b1)
		|=> timer1_flag_clr == !$past(st_r.irq_enable_reg_one[T1_IE_BIT])
		&& skip_next == ($past(t1_eff) && timer1_flag_clr))
		else $error("timer1 test wrong");
	timer2_test_a: assert property (
		run_op(OP_SKIP_ON_TIMER2_REQUEST, 1'b1)
		|=> timer2_flag_clr == !$past(st_r.irq_enable_reg_one[T2_IE_BIT])
		&& skip_next == ($past(t2_eff) && timer2_flag_clr))
		else $error("timer2 test wrong");
	squash_once_a: assert property (
		skip_then_word |-> instr_squash ##1 !skip_next)
		else $error("skipped word not replaced by one nop");
	irq_level_a: assert property (
		(st_r.status & st_r.mask) != '0 |-> irq)
		else $error("irq low with unmasked status set");

endmodule : skip_test_instruction_unit

/* File: logic/ext_pin_sync.sv */
// three-stage pin synchroniser with agreement filter for one level input
`timescale 1ns/1ns

module ext_pin_sync #(
	parameter logic RST_LEVEL = 1'b0
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic pin_async,
	output logic pin_level
);

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} sync_state_t;

	sync_state_t st_r;
	sync_state_t st_nxt;

	// the first stage feeds only the second; a level counts once the
	// second and third stages agree, so one metastable sample is dropped
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = pin_async;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		if (st_r.s2 == st_r.s3)
		begin
			st_nxt.lvl = st_r.s3;
		end
	end

	// synchronous reset loads constants only
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			st_r <= '{s1: RST_LEVEL, s2: RST_LEVEL, s3: RST_LEVEL,
				lvl: RST_LEVEL};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign pin_level = st_r.lvl;

endmodule : ext_pin_sync

/* File: dv/flag_source_model.sv */
// flag sources and interrupt pin that stand beside the skip test unit
`timescale 1ns/1ns

module flag_source_model (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [2:0] set_req,
	input wire logic pd_level,
	input wire logic pin_cmd,
	input wire logic ext0_flag_clr,
	input wire logic timer1_flag_clr,
	input wire logic timer2_flag_clr,
	output logic ext0_request_flag,
	output logic timer1_request_flag,
	output logic timer2_request_flag,
	output logic powerdown_flag,
	output logic ext0_pin
);
	// ---------------------------------------------------------------
	// request flags
	// ---------------------------------------------------------------
	// a new event beats a clear in the same cycle, so none is lost
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			ext0_request_flag <= 1'h0;
			timer1_request_flag <= 1'h0;
			timer2_request_flag <= 1'h0;
		end
		else
		begin
			ext0_request_flag <= set_req[0] |
				(ext0_request_flag & ~ext0_flag_clr);
			timer1_request_flag <= set_req[1] |
				(timer1_request_flag & ~timer1_flag_clr);
			timer2_request_flag <= set_req[2] |
				(timer2_request_flag & ~timer2_flag_clr);
		end
	end

	// power-down flag and pin follow the bench's command only
	assign powerdown_flag = pd_level;
	assign ext0_pin = pin_cmd;
endmodule : flag_source_model

/* File: dv/testbench.sv */
// self-checking bench for the skip test instruction unit
`timescale 1ns/1ns

module testbench;
	import skip_pkg::*;
	logic core_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic instr_valid = 1'h0;
	op_t instr_op = OP_OTHER;
	logic [3:0] acc_value = 4'h0;
	logic [3:0] mem_nibble = 4'h0;
	logic instr_squash, skip_next, irq, pready, pslverr, err;
	logic ext0_request_flag, timer1_request_flag, timer2_request_flag;
	logic powerdown_flag, ext0_pin;
	logic ext0_flag_clr, timer1_flag_clr, timer2_flag_clr;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [2:0] set_req = 3'h0;
	logic pd_level = 1'h0;
	logic pin_cmd = 1'h1;
	int n_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int m_pend, m_en, m_pol, m_stat, m_mask, w;
	int m_f[3];

	skip_test_instruction_unit skip_test_instruction_unit_inst (.*);
	flag_source_model flag_source_model_inst (.*);

	// ---------------------------------------------------------------
	// clock, timeout, reporting
	// ---------------------------------------------------------------
	initial forever #25 core_clk = ~core_clk;

	// a hang is cut short well after the expected run length
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_errors++;
			report_and_stop();
		end
	end

	task report_and_stop();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	task check(input logic [31:0] got, input logic [31:0] exp, string s);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
		end
	endtask : check

	// ---------------------------------------------------------------
	// apb master and instruction driver
	// ---------------------------------------------------------------
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		@(posedge core_clk);
		while (pready !== 1'h1) @(posedge core_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task rdchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
		apb(1'h0, a, 32'h0);
		check(rd, e, "read data");
		check(err, ee, "slave error");
	endtask : rdchk

	// results of one word, looked at one cycle after it was driven
	task chk_res(input int skip, input int clr);
		check(skip_next, skip, "skip");
		check({timer2_flag_clr, timer1_flag_clr, ext0_flag_clr}, clr,
			"clear");
		check(irq, (m_stat & m_mask) != 0, "irq");
	endtask : chk_res

	// n words back to back; each word is driven at a rising edge, so the
	// next word already stands while the previous result is checked
	task exec(input int n);
		int op, a, b, skip, clr;
		skip = 0;
		clr = 0;
		@(posedge core_clk);
		for (int i = 0; i <= n; i++)
		begin
			op = $urandom % 7;
			a = $urandom % 16;
			b = ($urandom % 2) ? a : $urandom % 16;
			instr_valid <= (i < n);
			instr_op <= op_t'(op);
			acc_value <= a[3:0];
			mem_nibble <= b[3:0];
			#1;
			if (i > 0) chk_res(skip, clr);
			if (i < n)
			begin
				check(instr_squash, m_pend, "squash");
				model_word(op, a, b, skip, clr);
				@(posedge core_clk);
			end
		end
	endtask : exec

	// rule model of one word; a pending skip turns it into a nop
	task model_word(input int op, a, b, output int skip, clr);
		int ev, f, eb;
		skip = 0;
		clr = 0;
		ev = 0;
		f = (op == 2) ? 0 : op - 4;
		eb = (f == 0) ? EXT0_IE_BIT : (f == 1 ? T1_IE_BIT : T2_IE_BIT);
		if (!m_pend)
			case (op)
				1: skip = (a == b);
				3: skip = ((m_pol >> POL_BIT) & 1) ? pin_cmd : !pin_cmd;
				4: skip = pd_level;
				2, 5, 6:
				begin
					if ((m_en >> eb) & 1) ev = 16;
					else
					begin
						clr = 1 << f;
						skip = m_f[f];
						ev = m_f[f] ? (2 << f) : 0;
						m_f[f] = 0;
					end
				end
				default: skip = 0;
			endcase
		ev |= skip;
		m_pend = skip;
		m_stat |= ev;
	endtask : model_word

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		void'($urandom(32'hC6730C17));
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'h0;
		{m_pend, m_en, m_pol, m_stat, m_mask} = '0;
		m_f = '{0, 0, 0};
		// reset values, then an unmapped word
		rdchk(ADDR_IRQ_EN, 32'h0, 1'h0);
		rdchk(ADDR_PIN_CTRL, 32'h0, 1'h0);
		rdchk(ADDR_STATUS, 32'h0, 1'h0);
		rdchk(ADDR_MASK, 32'h0, 1'h0);
		rdchk(ADDR_STATE, 32'h10, 1'h0);
		rdchk(8'h20, 32'h0, 1'h1);
		repeat (300)
		begin
			@(posedge core_clk);
			pin_cmd <= $urandom;
			pd_level <= $urandom;
			w = $urandom % 8;
			set_req <= w[2:0];
			for (int k = 0; k < 3; k++) if ((w >> k) & 1) m_f[k] = 1;
			@(posedge core_clk);
			set_req <= 3'h0;
			m_en = $urandom % 16;
			m_pol = $urandom % 16;
			apb(1'h1, ADDR_IRQ_EN, m_en);
			apb(1'h1, ADDR_PIN_CTRL, m_pol);
			if ($urandom % 4 == 0)
			begin
				m_mask = $urandom % 32;
				apb(1'h1, ADDR_MASK, m_mask);
			end
			exec(1 + $urandom % 2);
			rdchk(ADDR_STATUS, m_stat, 1'h0);
			rdchk(ADDR_STATE, (m_pend << 5) | (pin_cmd << 4) | (pd_level << 3)
				| (m_f[2] << 2) | (m_f[1] << 1) | m_f[0], 1'h0);
			w = $urandom % 32;
			apb(1'h1, ADDR_STATUS, w);
			m_stat &= ~w;
			#1 check(irq, (m_stat & m_mask) != 0, "irq after clear");
		end
		report_and_stop();
	end
endmodule : testbench
